// ### rtl/lsgc_consts.svh
// constants of the led sink serial gain control block
// assumes inclusion by the package and the design file
`ifndef LSGC_CONSTS_SVH
`define LSGC_CONSTS_SVH
`define LSGC_REG_W 16
`define LSGC_CFG_RESET 16'h00fe
`define LSGC_BAND_BIT 1
`define LSGC_MANT_MSB_BIT 2
`define LSGC_MANT_W 6
`define LSGC_HIST_W 10
`define LSGC_PAT_ENTER 10'h22e
`define LSGC_PAT_EXIT 10'h22a
`define LSGC_GAIN_BASE 8'h40
`define LSGC_GAIN_W 8
`define LSGC_GAIN_RESET 8'hfe
`define LSGC_FIFO_DEPTH 16
`define LSGC_PIN_N 4
`define LSGC_PIN_CLK 3
`define LSGC_PIN_DATA 2
`define LSGC_PIN_STROBE 1
`define LSGC_PIN_BLANK 0
`define LSGC_PIN_RESET 4'h1
`endif

// ### rtl/lsgc_pkg.sv
// types of the led sink serial gain control block
// assumes lsgc_consts.svh on the include path
`include "lsgc_consts.svh"
package lsgc_pkg;
    typedef struct packed {
        logic shift;
        logic data;
        logic strobe;
        logic blank;
    } lsgc_sample_t;

    typedef enum logic [1:0] {
        LSGC_MODE_NORMAL = 2'b01,
        LSGC_MODE_ADJUST = 2'b10
    } lsgc_mode_t;
endpackage : lsgc_pkg

// ### rtl/lsgc_core.sv
// serial front end of a 16-channel led sink driver, with its sample fifo
// assumes all pins are asynchronous to mclk and much slower than it
`timescale 1ns/1ps
`include "lsgc_consts.svh"

// ---------------------------------------------------------------
// sample fifo
// ---------------------------------------------------------------
module lsgc_fifo #(
    parameter int WIDTH = 4,
    parameter int DEPTH = 16
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [WIDTH-1:0] next_mem [DEPTH];
    logic [AW-1:0] wr_idx, next_wr_idx, rd_idx, next_rd_idx;
    logic [AW:0] count, next_count;
    logic push, pop;

    assign in_ready = (count != DEPTH[AW:0]);
    assign out_valid = (count != '0);
    assign out_data = mem[rd_idx];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        next_mem = mem;
        next_wr_idx = wr_idx;
        next_rd_idx = rd_idx;
        next_count = count;
        if (push) begin
            next_mem[wr_idx] = in_data;
            next_wr_idx = (wr_idx == AW'(DEPTH - 1)) ? '0 : wr_idx + 1'b1;
        end
        if (pop) begin
            next_rd_idx = (rd_idx == AW'(DEPTH - 1)) ? '0 : rd_idx + 1'b1;
        end
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        mem <= next_mem;
        if (!resetn) begin
            wr_idx <= '0;
            rd_idx <= '0;
            count <= '0;
        end else begin
            wr_idx <= next_wr_idx;
            rd_idx <= next_rd_idx;
            count <= next_count;
        end
    end
endmodule : lsgc_fifo

// ---------------------------------------------------------------
// top: pin sampling, shift register, latches, mode detect
// ---------------------------------------------------------------
module lsgc_core
    import lsgc_pkg::*;
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic shift_clk_pin,
    input wire logic serial_in_pin,
    input wire logic latch_strobe_pin,
    input wire logic output_blank_n_pin,
    input wire logic drain_hold,
    output logic serial_out_pin,
    output logic [`LSGC_REG_W-1:0] current_sink_outputs,
    output logic current_band_select,
    output logic [`LSGC_MANT_W-1:0] gain_mantissa,
    output logic [7:0] gain_x128,
    output logic adjust_mode,
    output logic sample_ready
);
    function automatic logic [`LSGC_MANT_W-1:0] mant_of(input logic [`LSGC_REG_W-1:0] c);
        logic [`LSGC_MANT_W-1:0] d;
        d = '0;
        for (int i = 0; i < `LSGC_MANT_W; i++) begin
            d[`LSGC_MANT_W-1-i] = c[`LSGC_MANT_MSB_BIT+i];
        end
        return d;
    endfunction : mant_of

    // ---------------------------------------------------------------
    // pin synchronisers and agreement filter
    // ---------------------------------------------------------------
    logic [`LSGC_PIN_N-1:0] pins, sync1, sync2, sync3, lvl, next_lvl;
    assign pins = {shift_clk_pin, serial_in_pin, latch_strobe_pin, output_blank_n_pin};

    genvar g;
    generate
        for (g = 0; g < `LSGC_PIN_N; g++) begin : g_filter
            always_comb begin
                next_lvl[g] = (sync2[g] == sync3[g]) ? sync3[g] : lvl[g];
            end
        end
    endgenerate

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            sync1 <= `LSGC_PIN_RESET;
            sync2 <= `LSGC_PIN_RESET;
            sync3 <= `LSGC_PIN_RESET;
            lvl <= `LSGC_PIN_RESET;
        end else begin
            sync1 <= pins;
            sync2 <= sync1;
            sync3 <= sync2;
            lvl <= next_lvl;
        end
    end

    // ---------------------------------------------------------------
    // sample capture into the fifo
    // ---------------------------------------------------------------
    lsgc_sample_t cap, smp;
    logic cap_valid, cap_ready, smp_valid, pop;

    always_comb begin
        cap.shift = next_lvl[`LSGC_PIN_CLK] && !lvl[`LSGC_PIN_CLK];
        cap.data = next_lvl[`LSGC_PIN_DATA];
        cap.strobe = next_lvl[`LSGC_PIN_STROBE];
        cap.blank = next_lvl[`LSGC_PIN_BLANK];
        cap_valid = cap.shift || (next_lvl[`LSGC_PIN_STROBE] != lvl[`LSGC_PIN_STROBE]);
    end

    lsgc_fifo #(
        .WIDTH($bits(lsgc_sample_t)),
        .DEPTH(`LSGC_FIFO_DEPTH)
    ) u_fifo (
        .mclk(mclk),
        .resetn(resetn),
        .in_data(cap),
        .in_valid(cap_valid),
        .in_ready(cap_ready),
        .out_data(smp),
        .out_valid(smp_valid),
        .out_ready(!drain_hold)
    );
    assign pop = smp_valid && !drain_hold;

    // ---------------------------------------------------------------
    // shift register, latches and mode
    // ---------------------------------------------------------------
    lsgc_mode_t mode, next_mode;
    logic [`LSGC_HIST_W-1:0] hist, next_hist;
    logic [`LSGC_REG_W-1:0] sreg, next_sreg, out_latch, next_latch, cfg, next_cfg;
    logic [`LSGC_REG_W-1:0] next_sinks;
    logic strobe_prev, next_strobe_prev, cfg_load;
    logic [`LSGC_GAIN_W-1:0] gain_base, next_gain;

    always_comb begin
        next_mode = mode;
        next_hist = hist;
        next_sreg = sreg;
        next_latch = out_latch;
        next_cfg = cfg;
        next_strobe_prev = strobe_prev;
        cfg_load = 1'b0;
        if (pop) begin
            next_strobe_prev = smp.strobe;
            if (smp.shift) begin
                next_sreg = {sreg[`LSGC_REG_W-2:0], smp.data};
                next_hist = {hist[`LSGC_HIST_W-3:0], smp.blank, smp.strobe};
            end
            if (mode == LSGC_MODE_ADJUST) begin
                if (smp.strobe && !strobe_prev) begin
                    cfg_load = 1'b1;
                    next_cfg = next_sreg;
                end
            end else if (smp.strobe) begin
                next_latch = next_sreg;
            end
            if (smp.shift) begin
                // five newest pairs, oldest in the top bits, against both patterns
                case (next_hist)
                    `LSGC_PAT_ENTER: next_mode = LSGC_MODE_ADJUST;
                    `LSGC_PAT_EXIT: next_mode = LSGC_MODE_NORMAL;
                    default: next_mode = mode;
                endcase
            end
        end
        next_sinks = lvl[`LSGC_PIN_BLANK] ? '0 : out_latch;
        gain_base = `LSGC_GAIN_BASE + {2'h0, mant_of(cfg)};
        next_gain = cfg[`LSGC_BAND_BIT] ? {gain_base[`LSGC_GAIN_W-2:0], 1'b0} : gain_base;
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            mode <= LSGC_MODE_NORMAL;
            hist <= '0;
            sreg <= '0;
            out_latch <= '0;
            cfg <= `LSGC_CFG_RESET;
            strobe_prev <= 1'b0;
            serial_out_pin <= 1'b0;
            current_sink_outputs <= '0;
            current_band_select <= 1'b1;
            gain_mantissa <= '1;
            gain_x128 <= `LSGC_GAIN_RESET;
            adjust_mode <= 1'b0;
            sample_ready <= 1'b1;
        end else begin
            mode <= next_mode;
            hist <= next_hist;
            sreg <= next_sreg;
            out_latch <= next_latch;
            cfg <= next_cfg;
            strobe_prev <= next_strobe_prev;
            serial_out_pin <= next_sreg[`LSGC_REG_W-1];
            current_sink_outputs <= next_sinks;
            current_band_select <= cfg[`LSGC_BAND_BIT];
            gain_mantissa <= mant_of(cfg);
            gain_x128 <= next_gain;
            adjust_mode <= (next_mode == LSGC_MODE_ADJUST);
            sample_ready <= cap_ready;
        end
    end

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    a_mode_enter: assert property (pop && smp.shift && next_hist == `LSGC_PAT_ENTER
        |=> mode == LSGC_MODE_ADJUST ##0 adjust_mode)
        else $error("enter pattern did not select adjust mode");
    a_mode_exit: assert property (pop && smp.shift && next_hist == `LSGC_PAT_EXIT
        |=> mode == LSGC_MODE_NORMAL && !adjust_mode)
        else $error("exit pattern did not select normal mode");
    a_shift_in: assert property (pop && smp.shift
        |=> sreg == {$past(sreg[`LSGC_REG_W-2:0]), $past(smp.data)}
        && serial_out_pin == sreg[`LSGC_REG_W-1])
        else $error("shift register did not take the serial bit");
    a_cfg_load: assert property (cfg_load |=> cfg == $past(next_sreg) && $stable(out_latch))
        else $error("config strobe did not load config latch only");
    a_latch_follow: assert property (pop && mode == LSGC_MODE_NORMAL && smp.strobe
        |=> out_latch == $past(next_sreg) && $stable(cfg))
        else $error("output latch did not follow in normal mode");
    a_cfg_keep: assert property (!cfg_load |=> $stable(cfg))
        else $error("config latch changed without a strobe");
    a_blank_off: assert property (lvl[`LSGC_PIN_BLANK] |=> current_sink_outputs == '0)
        else $error("sinks on while blanked");
    a_sink_follow: assert property (!lvl[`LSGC_PIN_BLANK] && $stable(out_latch)
        |=> current_sink_outputs == $past(out_latch))
        else $error("sinks do not follow the output latch");
    a_gain_value: assert property ($stable(cfg) [*2]
        |-> gain_x128 == ((`LSGC_GAIN_BASE + mant_of($past(cfg))) << $past(cfg[`LSGC_BAND_BIT])))
        else $error("gain value does not match config latch");
    a_adjust_hold: assert property (pop && mode == LSGC_MODE_ADJUST
        |=> $stable(out_latch))
        else $error("output latch changed in adjust mode");
    a_sink_adjust: assert property (mode == LSGC_MODE_ADJUST && !lvl[`LSGC_PIN_BLANK]
        |=> current_sink_outputs == $past(out_latch))
        else $error("sinks do not follow the latch in adjust mode");
    a_band_output: assert property (cfg_load
        |=> ##1 current_band_select == $past(cfg[`LSGC_BAND_BIT]))
        else $error("band select output does not match config latch");
    a_mant_order: assert property (cfg_load
        |=> ##1 gain_mantissa[`LSGC_MANT_W-1] == $past(cfg[`LSGC_MANT_MSB_BIT])
        && gain_mantissa[0] == $past(cfg[`LSGC_MANT_MSB_BIT+`LSGC_MANT_W-1]))
        else $error("mantissa bit order does not match config latch");

    c_enter: cover property (mode == LSGC_MODE_NORMAL ##1 mode == LSGC_MODE_ADJUST);
    c_write: cover property (cfg_load ##1 cfg != `LSGC_CFG_RESET);
    c_exit: cover property (mode == LSGC_MODE_ADJUST ##1 mode == LSGC_MODE_NORMAL);
    c_full: cover property (!cap_ready);
    c_low_band: cover property (cfg_load ##1 !cfg[`LSGC_BAND_BIT]);
endmodule : lsgc_core

// ### tb/lsgc_ctrl_model.sv
// controller model driving the pin link of the sink driver
// assumes mclk is the device clock; pins move 1 ns after its edge
`timescale 1ns/1ps
// ----------------------------------------
// pin driver
// ----------------------------------------
module lsgc_ctrl_model (
    input wire logic mclk,
    output logic shift_clk_pin,
    output logic serial_in_pin,
    output logic latch_strobe_pin,
    output logic output_blank_n_pin
);
    initial begin
        shift_clk_pin = 1'b0;
        serial_in_pin = 1'b0;
        latch_strobe_pin = 1'b0;
        output_blank_n_pin = 1'b1;
    end
    task automatic wait_clk(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : wait_clk
    // pair held steady around the pin clock rise
    task automatic send(input logic d, input logic b, input logic s);
        wait_clk(1);
        serial_in_pin = d;
        output_blank_n_pin = b;
        latch_strobe_pin = s;
        wait_clk(4);
        shift_clk_pin = 1'b1;
        wait_clk(4);
        shift_clk_pin = 1'b0;
        wait_clk(4);
        latch_strobe_pin = 1'b0;
        wait_clk(4);
    endtask : send
    task automatic pulse();
        wait_clk(1);
        latch_strobe_pin = 1'b1;
        wait_clk(4);
        latch_strobe_pin = 1'b0;
        wait_clk(4);
    endtask : pulse
endmodule : lsgc_ctrl_model

// ### tb/test_lsgc_core.sv
// self-checking bench of the led sink serial gain control core
// assumes lsgc_pkg, lsgc_core and lsgc_ctrl_model compiled before
`timescale 1ns/1ps
`include "lsgc_consts.svh"
// ----------------------------------------
// bench
// ----------------------------------------
module test_lsgc_core
    import lsgc_pkg::*;
;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic drain_hold = 1'b0;
    logic shift_clk_pin, serial_in_pin, latch_strobe_pin, output_blank_n_pin;
    logic serial_out_pin, current_band_select, adjust_mode, sample_ready;
    logic [`LSGC_REG_W-1:0] current_sink_outputs;
    logic [`LSGC_MANT_W-1:0] gain_mantissa;
    logic [7:0] gain_x128;
    int tests_run = 0;
    int bad_count = 0;
    logic [15:0] exp_sreg = 16'h0000;
    logic [15:0] exp_latch = 16'h0000;
    logic [15:0] exp_cfg = 16'h00fe;
    logic exp_adj = 1'b0;
    logic [15:0] codes [3] = '{16'h0054, 16'h0002, 16'hff01};

    always #2.5 mclk = ~mclk;

    lsgc_core lsgc_core_i (.mclk, .resetn, .shift_clk_pin, .serial_in_pin,
        .latch_strobe_pin, .output_blank_n_pin, .drain_hold, .serial_out_pin,
        .current_sink_outputs, .current_band_select, .gain_mantissa, .gain_x128,
        .adjust_mode, .sample_ready);
    lsgc_ctrl_model lsgc_ctrl_model_i (.mclk, .shift_clk_pin, .serial_in_pin,
        .latch_strobe_pin, .output_blank_n_pin);

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_of_test
    task automatic xbit(input logic d, input logic b, input logic s);
        lsgc_ctrl_model_i.send(d, b, s);
        exp_sreg = {exp_sreg[14:0], d};
        if (s && !exp_adj) begin
            exp_latch = exp_sreg;
        end
    endtask : xbit
    task automatic word(input logic [15:0] w);
        for (int i = 15; i >= 0; i--) begin
            xbit(w[i], 1'b0, 1'b0);
        end
    endtask : word
    // five (blank, strobe) pairs, oldest in the top bits
    task automatic pattern(input logic [9:0] p);
        for (int i = 4; i >= 0; i--) begin
            xbit(i[0], p[2*i+1], p[2*i]);
        end
    endtask : pattern
    task automatic strobe();
        lsgc_ctrl_model_i.pulse();
        if (exp_adj) begin
            exp_cfg = exp_sreg;
        end else begin
            exp_latch = exp_sreg;
        end
    endtask : strobe
    task automatic chk_all();
        logic [5:0] d;
        repeat (10) @(posedge mclk);
        #1;
        d = {exp_cfg[2], exp_cfg[3], exp_cfg[4], exp_cfg[5], exp_cfg[6], exp_cfg[7]};
        check(current_sink_outputs, output_blank_n_pin ? 16'h0 : exp_latch);
        check(serial_out_pin, exp_sreg[15]);
        check(adjust_mode, exp_adj);
        check(current_band_select, exp_cfg[1]);
        check(gain_mantissa, d);
        check(gain_x128, (8'h40 + d) << exp_cfg[1]);
    endtask : chk_all

    initial begin
        repeat (4) @(posedge mclk);
        #1 resetn = 1'b1;
        repeat (4) @(posedge mclk);
        chk_all();
        check(sample_ready, 1'b1);
        $display("test reset done");
        word(16'ha5c3);
        strobe();
        chk_all();
        xbit(1'b0, 1'b1, 1'b0);
        chk_all();
        $display("test normal done");
        pattern(10'h22e);
        exp_adj = 1'b1;
        chk_all();
        foreach (codes[k]) begin
            word(codes[k]);
            chk_all();
            strobe();
            chk_all();
        end
        $display("test adjust done");
        pattern(10'h22a);
        exp_adj = 1'b0;
        chk_all();
        word(16'h3c5a);
        strobe();
        chk_all();
        $display("test resume done");
        drain_hold = 1'b1;
        repeat (9) lsgc_ctrl_model_i.pulse();
        check(sample_ready, 1'b0);
        drain_hold = 1'b0;
        repeat (30) @(posedge mclk);
        #1;
        check(sample_ready, 1'b1);
        $display("test fifo done");
        @(posedge mclk);
        #1 resetn = 1'b0;
        repeat (4) @(posedge mclk);
        #1 resetn = 1'b1;
        exp_sreg = 16'h0000;
        exp_latch = 16'h0000;
        exp_cfg = 16'h00fe;
        chk_all();
        $display("test reset again done");
        end_of_test();
    end

    initial begin
        repeat (20000) @(posedge mclk);
        bad_count++;
        end_of_test();
    end
endmodule : test_lsgc_core
